// ---- dwu_pkg.sv ----
/*
 * Package of the dual watchdog unit: register offsets, field positions,
 * reset values, key codes and timing figures.
 * Assumes a 32-bit APB with byte addresses and one word per register.
 */
package dwu_pkg;

  // Timing
  localparam int unsigned PCLK_HZ = 20_000_000;
  localparam int unsigned OSC_HZ  = 37_000;
  localparam int unsigned OSC_MIN_PCLK = PCLK_HZ / (2 * OSC_HZ);

  // Widths
  localparam int unsigned IWD_CNT_W = 12;
  localparam int unsigned IWD_PRE_W = 8;
  localparam int unsigned WWD_CNT_W = 7;

  // Register offsets
  localparam logic [7:0] OFS_IWD_KEY    = 8'h00;
  localparam logic [7:0] OFS_IWD_PRESC  = 8'h04;
  localparam logic [7:0] OFS_IWD_RELOAD = 8'h08;
  localparam logic [7:0] OFS_IWD_COUNT  = 8'h0C;
  localparam logic [7:0] OFS_WWD_CTRL   = 8'h10;
  localparam logic [7:0] OFS_WWD_WINDOW = 8'h14;
  localparam logic [7:0] OFS_CONFIG     = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h20;

  // Key codes
  localparam logic [15:0] KEY_RELOAD = 16'hAAAA;
  localparam logic [15:0] KEY_START  = 16'hCCCC;

  // Field positions
  localparam int unsigned WWD_EN_BIT      = 7;
  localparam int unsigned CFG_IWD_RST_BIT = 0;
  localparam int unsigned CFG_IWD_DBG_BIT = 1;
  localparam int unsigned CFG_WWD_DBG_BIT = 2;
  localparam int unsigned IRQ_EWI_BIT     = 0;
  localparam int unsigned IRQ_IWD_TO_BIT  = 1;
  localparam int unsigned IRQ_W           = 2;

  // Reset values
  localparam logic [IWD_CNT_W-1:0] RST_IWD_RELOAD = 12'hFFF;
  localparam logic [IWD_PRE_W-1:0] RST_IWD_PRESC  = 8'h00;
  localparam logic [WWD_CNT_W-1:0] RST_WWD_CNT    = 7'h7F;
  localparam logic [WWD_CNT_W-1:0] RST_WWD_WINDOW = 7'h7F;
  localparam logic [2:0]           RST_CONFIG     = 3'h1;

  // Windowed watchdog thresholds
  localparam logic [WWD_CNT_W-1:0] WWD_WARN = 7'h40;
  localparam logic [WWD_CNT_W-1:0] WWD_LAST = 7'h3F;

  typedef enum logic [0:0] {
    IWD_IDLE = 1'b0,
    IWD_RUN  = 1'b1
  } dwu_iwd_state_type;

  typedef struct packed {
    logic wwd_dbg_freeze;
    logic iwd_dbg_freeze;
    logic iwd_reset_mode;
  } dwu_cfg_type;

endpackage : dwu_pkg

// ---- dwu_top.sv ----
/*
 * Dual watchdog unit: an independent watchdog counted on a sampled slow
 * oscillator and a windowed watchdog counted on pclk, behind an APB slave.
 * Assumes the slow oscillator arrives as a plain pin and the system reset
 * controller acts on sys_reset_req.
 */
`timescale 1ns/1ps
`default_nettype none

module dwu_top #(
  parameter int unsigned WWD_DIV = 4096
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System
  input  wire logic        osc_in,
  input  wire logic        hw_start_opt,
  input  wire logic        dbg_halt,
  input  wire logic        low_power,
  output logic             sys_reset_req,
  output logic             irq
);

  // Divider counter is 16 bits wide, so larger ratios cannot be served
  if (WWD_DIV < 1 || WWD_DIV > 65536) begin : g_div_check
    $error("WWD_DIV out of range");
  end


  localparam int unsigned IW = dwu_pkg::IWD_CNT_W;
  localparam int unsigned PW = dwu_pkg::IWD_PRE_W;
  localparam int unsigned WW = dwu_pkg::WWD_CNT_W;
  localparam int unsigned IRQ_W_C = dwu_pkg::IRQ_W;

  // Oscillator sampling: three stages, edge once stage 2 and 3 agree
  logic [2:0] osc_sync_r;
  logic [2:0] osc_sync_nxt;
  logic       osc_lvl_r;
  logic       osc_lvl_nxt;
  logic       osc_tick;

  always_comb begin
    osc_sync_nxt = {osc_sync_r[1:0], osc_in};
    osc_lvl_nxt  = osc_lvl_r;
    osc_tick     = 1'b0;
    if (osc_sync_r[1] == osc_sync_r[2]) begin
      osc_lvl_nxt = osc_sync_r[2];
      osc_tick    = osc_sync_r[2] & ~osc_lvl_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_r <= 3'h0;
      osc_lvl_r  <= 1'b0;
    end else if (clk_en) begin
      osc_sync_r <= osc_sync_nxt;
      osc_lvl_r  <= osc_lvl_nxt;
    end
  end

  // APB decode
  logic acc_rd;
  logic acc_wr;
  logic mapped;

  always_comb begin
    case (paddr)
      dwu_pkg::OFS_IWD_KEY, dwu_pkg::OFS_IWD_PRESC, dwu_pkg::OFS_IWD_RELOAD,
      dwu_pkg::OFS_IWD_COUNT, dwu_pkg::OFS_WWD_CTRL, dwu_pkg::OFS_WWD_WINDOW,
      dwu_pkg::OFS_CONFIG, dwu_pkg::OFS_IRQ_STAT, dwu_pkg::OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Registers and counters
  logic [31:0]             prdata_r,  prdata_nxt;
  logic                    pready_r,  pready_nxt;
  logic                    pslverr_r, pslverr_nxt;
  logic [PW-1:0]           presc_r,   presc_nxt;
  logic [IW-1:0]           reload_r,  reload_nxt;
  logic [PW-1:0]           pdiv_r,    pdiv_nxt;
  logic [IW-1:0]           icnt_r,    icnt_nxt;
  dwu_pkg::dwu_iwd_state_type ist_r,  ist_nxt;
  logic                    hw_seen_r, hw_seen_nxt;
  logic [WW-1:0]           wcnt_r,    wcnt_nxt;
  logic [WW-1:0]           window_r,  window_nxt;
  logic                    wen_r,     wen_nxt;
  logic [15:0]             wdiv_r,    wdiv_nxt;
  dwu_pkg::dwu_cfg_type    cfg_r,     cfg_nxt;
  logic [IRQ_W_C-1:0]      stat_r,    stat_nxt;
  logic [IRQ_W_C-1:0]      mask_r,    mask_nxt;
  logic                    rst_r,     rst_nxt;
  logic                    irq_r,     irq_nxt;

  logic [IRQ_W_C-1:0] ev;
  logic               iwd_step;
  logic               wwd_step;
  logic               wwd_bad;

  // Read data is taken a cycle early so it stands together with pready
  assign acc_rd = psel & penable & ~pready_r & ~pwrite;
  // Write lands on the edge at which the master sees pready
  assign acc_wr = psel & penable & pready_r & pwrite;

  always_comb begin
    prdata_nxt  = prdata_r;
    pready_nxt  = psel & penable & ~pready_r;
    pslverr_nxt = psel & penable & ~pready_r & ~mapped;
    presc_nxt   = presc_r;
    reload_nxt  = reload_r;
    pdiv_nxt    = pdiv_r;
    icnt_nxt    = icnt_r;
    ist_nxt     = ist_r;
    hw_seen_nxt = 1'b1;
    wcnt_nxt    = wcnt_r;
    window_nxt  = window_r;
    wen_nxt     = wen_r;
    wdiv_nxt    = wdiv_r;
    cfg_nxt     = cfg_r;
    mask_nxt    = mask_r;
    ev          = '0;
    rst_nxt     = 1'b0;
    wwd_bad     = 1'b0;

    // Strap caught once after reset release
    if (!hw_seen_r && hw_start_opt) begin
      ist_nxt = dwu_pkg::IWD_RUN;
    end

    // Independent watchdog: ticks ignore low_power on purpose
    iwd_step = osc_tick & (ist_r == dwu_pkg::IWD_RUN)
             & ~(dbg_halt & cfg_r.iwd_dbg_freeze);
    if (iwd_step) begin
      if (pdiv_r >= presc_r) begin
        pdiv_nxt = '0;
        if (icnt_r == '0) begin
          icnt_nxt = reload_r;
          if (cfg_r.iwd_reset_mode) begin
            rst_nxt = 1'b1;
          end else begin
            ev[dwu_pkg::IRQ_IWD_TO_BIT] = 1'b1;
          end
        end else begin
          icnt_nxt = icnt_r - 1'b1;
        end
      end else begin
        pdiv_nxt = pdiv_r + 1'b1;
      end
    end

    // Windowed watchdog: stopped with the main clock in low power
    // Counter wraps from 00 to 7F when left running
    wwd_step = ~low_power & ~(dbg_halt & cfg_r.wwd_dbg_freeze);
    if (wwd_step) begin
      if (wdiv_r >= 16'(WWD_DIV - 1)) begin
        wdiv_nxt = '0;
        wcnt_nxt = wcnt_r - 1'b1;
        if (wcnt_r == dwu_pkg::WWD_WARN) begin
          ev[dwu_pkg::IRQ_EWI_BIT] = 1'b1;
          wwd_bad = wen_r;
        end
      end else begin
        wdiv_nxt = wdiv_r + 1'b1;
      end
    end

    // Register reads
    if (acc_rd) begin
      case (paddr)
        dwu_pkg::OFS_IWD_PRESC:  prdata_nxt = 32'(presc_r);
        dwu_pkg::OFS_IWD_RELOAD: prdata_nxt = 32'(reload_r);
        dwu_pkg::OFS_IWD_COUNT:  prdata_nxt = {15'h0000, ist_r == dwu_pkg::IWD_RUN,
                                              4'h0, icnt_r};
        dwu_pkg::OFS_WWD_CTRL:   prdata_nxt = {24'h000000, wen_r, wcnt_r};
        dwu_pkg::OFS_WWD_WINDOW: prdata_nxt = 32'(window_r);
        dwu_pkg::OFS_CONFIG:     prdata_nxt = 32'(cfg_r);
        dwu_pkg::OFS_IRQ_STAT:   prdata_nxt = 32'(stat_r);
        dwu_pkg::OFS_IRQ_MASK:   prdata_nxt = 32'(mask_r);
        default:                 prdata_nxt = 32'h00000000;
      endcase
    end

    // Register writes
    if (acc_wr) begin
      case (paddr)
        dwu_pkg::OFS_IWD_KEY: begin
          if (pwdata[15:0] == dwu_pkg::KEY_START) begin
            ist_nxt  = dwu_pkg::IWD_RUN;
            icnt_nxt = reload_r;
            pdiv_nxt = '0;
          end else if (pwdata[15:0] == dwu_pkg::KEY_RELOAD) begin
            icnt_nxt = reload_r;
            pdiv_nxt = '0;
          end
        end
        dwu_pkg::OFS_IWD_PRESC:  presc_nxt  = pwdata[PW-1:0];
        dwu_pkg::OFS_IWD_RELOAD: reload_nxt = pwdata[IW-1:0];
        dwu_pkg::OFS_WWD_CTRL: begin
          if (wen_r && wcnt_r > window_r) begin
            wwd_bad = 1'b1;
          end else begin
            wcnt_nxt = pwdata[WW-1:0];
            wdiv_nxt = '0;
          end
          // Enable is sticky until reset
          wen_nxt = wen_r | pwdata[dwu_pkg::WWD_EN_BIT];
        end
        dwu_pkg::OFS_WWD_WINDOW: window_nxt = pwdata[WW-1:0];
        dwu_pkg::OFS_CONFIG:     cfg_nxt    = pwdata[2:0];
        dwu_pkg::OFS_IRQ_MASK:   mask_nxt   = pwdata[IRQ_W_C-1:0];
        default: ;
      endcase
    end

    if (wwd_bad) begin
      rst_nxt = 1'b1;
    end

    // Sticky status: a new event wins over a write-one clear
    stat_nxt = stat_r;
    if (acc_wr && paddr == dwu_pkg::OFS_IRQ_STAT) begin
      stat_nxt = stat_r & ~pwdata[IRQ_W_C-1:0];
    end
    stat_nxt = stat_nxt | ev;
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      presc_r   <= dwu_pkg::RST_IWD_PRESC;
      reload_r  <= dwu_pkg::RST_IWD_RELOAD;
      pdiv_r    <= '0;
      icnt_r    <= dwu_pkg::RST_IWD_RELOAD;
      ist_r     <= dwu_pkg::IWD_IDLE;
      hw_seen_r <= 1'b0;
      wcnt_r    <= dwu_pkg::RST_WWD_CNT;
      window_r  <= dwu_pkg::RST_WWD_WINDOW;
      wen_r     <= 1'b0;
      wdiv_r    <= 16'h0000;
      cfg_r     <= dwu_pkg::RST_CONFIG;
      stat_r    <= '0;
      mask_r    <= '0;
      rst_r     <= 1'b0;
      irq_r     <= 1'b0;
    end else if (clk_en) begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      presc_r   <= presc_nxt;
      reload_r  <= reload_nxt;
      pdiv_r    <= pdiv_nxt;
      icnt_r    <= icnt_nxt;
      ist_r     <= ist_nxt;
      hw_seen_r <= hw_seen_nxt;
      wcnt_r    <= wcnt_nxt;
      window_r  <= window_nxt;
      wen_r     <= wen_nxt;
      wdiv_r    <= wdiv_nxt;
      cfg_r     <= cfg_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      rst_r     <= rst_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign sys_reset_req = rst_r;
  assign irq           = irq_r;

endmodule // dwu_top

`default_nettype wire

// ---- dwu_top_monitor.sv ----
/* Port checker of the dual watchdog unit.
   Bound into dwu_top; sees its APB, reset request and irq ports. */
`timescale 1ns/1ps
`default_nettype none
module dwu_top_monitor #(
  parameter int unsigned WWD_DIV = 4096
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // System
  input wire logic        sys_reset_req,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // One wait state, always
  ack_slot_a: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready missing in second access cycle");
  ack_once_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ack_in_xfer_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  err_with_ack_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_once_a: assert property (pslverr |=> !pslverr)
    else $error("pslverr longer than one cycle");
  data_hold_a: assert property ($changed(prdata) |-> pready)
    else $error("prdata moved outside a read answer");
  rst_pulse_a: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request held");
  irq_clear_a: assert property ($fell(irq) |-> $past(pready && pwrite, 1))
    else $error("irq fell without a register write");
endmodule // dwu_top_monitor

bind dwu_top dwu_top_monitor #(.WWD_DIV(WWD_DIV)) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sys_reset_req(sys_reset_req), .irq(irq));
`default_nettype wire

// ---- dwu_top_tb.sv ----
/* Self-checking bench of dwu_top through APB register calls.
   Drives all inputs; oscillator ticks are stepped by the bench. */
`timescale 1ns/1ps
`default_nettype none
module dwu_top_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, osc_in = 1'b0, hw_start_opt = 1'b0;
  logic        dbg_halt = 1'b0, low_power = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, sys_reset_req, irq, err;
  int          errors = 0, checked = 0, rst_seen = 0, r0;

  always #25 pclk = ~pclk;
  always @(posedge pclk) if (sys_reset_req === 1'b1) rst_seen <= rst_seen + 1;

  // Short divider keeps the windowed period near 512 cycles
  dwu_top #(.WWD_DIV(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
    .hw_start_opt(hw_start_opt), .dbg_halt(dbg_halt),
    .low_power(low_power), .sys_reset_req(sys_reset_req), .irq(irq));

  task automatic test_done();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never re-raises psel in this step
    @(posedge pclk);
    if (n >= 50) begin errors++; test_done(); end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask

  // Slow tick kept well above the three-flop sampler
  task automatic ticks(input int n);
    repeat (n) begin
      osc_in <= 1'b1; repeat (10) @(posedge pclk);
      osc_in <= 1'b0; repeat (10) @(posedge pclk);
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0; repeat (12) @(posedge pclk);
    presetn <= 1'b1; @(posedge pclk);
  endtask

  initial begin
    do_reset();
    rdc("presc", dwu_pkg::OFS_IWD_PRESC, 32'h0);
    rdc("reload", dwu_pkg::OFS_IWD_RELOAD, 32'hFFF);
    rdc("config", dwu_pkg::OFS_CONFIG, 32'h1);
    rdc("mask", dwu_pkg::OFS_IRQ_MASK, 32'h0);
    wr(dwu_pkg::OFS_IWD_COUNT, 32'h0);
    rdc("count", dwu_pkg::OFS_IWD_COUNT, 32'hFFF);
    rdc("unmapped", 8'h24, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    wr(dwu_pkg::OFS_CONFIG, 32'h0);
    wr(dwu_pkg::OFS_IWD_PRESC, 32'h1);
    wr(dwu_pkg::OFS_IWD_RELOAD, 32'h5);
    wr(dwu_pkg::OFS_IRQ_MASK, 32'h2);
    wr(dwu_pkg::OFS_IWD_KEY, 32'hCCCC);
    rdc("started", dwu_pkg::OFS_IWD_COUNT, 32'h10005);
    low_power <= 1'b1;
    ticks(2);
    rdc("low power", dwu_pkg::OFS_IWD_COUNT, 32'h10004);
    low_power <= 1'b0;
    wr(dwu_pkg::OFS_CONFIG, 32'h2);
    dbg_halt <= 1'b1;
    ticks(4);
    rdc("iwd frozen", dwu_pkg::OFS_IWD_COUNT, 32'h10004);
    dbg_halt <= 1'b0;
    wr(dwu_pkg::OFS_CONFIG, 32'h0);
    ticks(2);
    rdc("iwd thawed", dwu_pkg::OFS_IWD_COUNT, 32'h10003);
    wr(dwu_pkg::OFS_IWD_KEY, 32'hAAAA);
    rdc("reloaded", dwu_pkg::OFS_IWD_COUNT, 32'h10005);
    r0 = rst_seen;
    ticks(12);
    check("timeout irq", {31'h0, irq}, 32'h1);
    check("timer no rst", rst_seen - r0, 32'h0);
    wr(dwu_pkg::OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(dwu_pkg::OFS_CONFIG, 32'h1);
    ticks(12);
    check("iwd rst", rst_seen - r0, 32'h1);
    wr(dwu_pkg::OFS_WWD_CTRL, 32'h70);
    wr(dwu_pkg::OFS_IRQ_STAT, 32'h3);
    wr(dwu_pkg::OFS_IRQ_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    check("ewi idle", {31'h0, irq}, 32'h0);
    wr(dwu_pkg::OFS_WWD_CTRL, 32'h41);
    repeat (20) @(posedge pclk);
    check("ewi irq", {31'h0, irq}, 32'h1);
    rdc("ewi stat", dwu_pkg::OFS_IRQ_STAT, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(dwu_pkg::OFS_CONFIG, k ? 32'h5 : 32'h1);
      low_power <= ~k[0];
      dbg_halt <= k[0];
      wr(dwu_pkg::OFS_WWD_CTRL, 32'h70);
      repeat (40) @(posedge pclk);
      rdc("wwd hold", dwu_pkg::OFS_WWD_CTRL, 32'h70);
    end
    low_power <= 1'b0;
    dbg_halt <= 1'b0;
    wr(dwu_pkg::OFS_WWD_WINDOW, 32'h50);
    wr(dwu_pkg::OFS_WWD_CTRL, 32'hE0);
    r0 = rst_seen;
    wr(dwu_pkg::OFS_WWD_CTRL, 32'hE0);
    repeat (3) @(posedge pclk);
    check("early refresh", rst_seen - r0, 32'h1);
    repeat (100) @(posedge pclk);
    wr(dwu_pkg::OFS_WWD_CTRL, 32'hC8);
    repeat (3) @(posedge pclk);
    check("legal refresh", rst_seen - r0, 32'h1);
    repeat (60) @(posedge pclk);
    check("wwd expiry", rst_seen - r0, 32'h2);
    // Strap is sampled only once, right after release
    hw_start_opt <= 1'b1;
    do_reset();
    rdc("hw start", dwu_pkg::OFS_IWD_COUNT, 32'h10FFF);
    test_done();
  end
endmodule // dwu_top_tb
`default_nettype wire
